// ===== src/hub_strap_pkg.sv
package hub_strap_pkg;

   // ***************************************************************
   // register bus
   // ***************************************************************
   localparam int AXI_AW = 8;
   localparam int AXI_DW = 32;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STRAP_OFS = 8'h04;
   localparam logic [7:0] LINK_OFS = 8'h08;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // control word fields
   localparam int CTRL_PWR_BIT = 0;
   localparam logic CTRL_PWR_RESET = 1'h1;

   // strap status word fields
   localparam int ST_PM_BIT = 0;
   localparam int ST_GANG_BIT = 1;
   localparam int ST_IND_BIT = 2;
   localparam int ST_PKG_BIT = 3;
   localparam int ST_EEPROM_BIT = 4;
   localparam int ST_DONE_BIT = 5;
   localparam int ST_ADDR_LSB = 8;

   // link status word fields
   localparam int LK_HSPD_BIT = 0;
   localparam int LK_SS_BIT = 1;

   // ***************************************************************
   // straps
   // ***************************************************************
   localparam int STRAP_W = 4;
   localparam int SV_PM = 0;
   localparam int SV_GANG = 1;
   localparam int SV_IND = 2;
   localparam int SV_PKG = 3;
   localparam logic [STRAP_W-1:0] STRAP_RESET = 4'hF;
   // synchroniser depth, so the captured level is the pin after release
   localparam logic [1:0] CAPTURE_WAIT = 2'h2;

   // ***************************************************************
   // serial slave address
   // ***************************************************************
   localparam logic [3:0] ADDR_FIXED = 4'h8;
   localparam logic SMB_DIR_READ = 1'h1;
   localparam logic SMB_DIR_WRITE = 1'h0;

endpackage

// ===== src/sync2.sv
`timescale 1ns/1ps
module sync2 import hub_strap_pkg::*;
#(
   parameter int W = 1
)
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [W-1:0] D,
   output logic [W-1:0] Q
);

   typedef struct packed
   {
      logic [W-1:0] meta;
      logic [W-1:0] safe;
   } sync_st_t;

   sync_st_t st_ff;
   sync_st_t nxt_st;

   // first stage feeds only the second stage
   always_comb
   begin
      nxt_st.meta = D;
      nxt_st.safe = st_ff.meta;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign Q = st_ff.safe;

endmodule

// ===== src/strap_latch.sv
`timescale 1ns/1ps
module strap_latch import hub_strap_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [STRAP_W-1:0] D,
   output logic [STRAP_W-1:0] Q,
   output logic DONE
);

   typedef struct packed
   {
      logic [1:0] cnt;
      logic done;
      logic [STRAP_W-1:0] val;
   } latch_st_t;

   latch_st_t st_ff;
   latch_st_t nxt_st;

   // wait out the synchroniser, sample once, then hold until next reset
   always_comb
   begin
      nxt_st = st_ff;
      if (!st_ff.done)
      begin
         if (st_ff.cnt == CAPTURE_WAIT)
         begin
            nxt_st.val = D;
            nxt_st.done = 1'b1;
         end
         else
            nxt_st.cnt = st_ff.cnt + 2'h1;
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         st_ff.cnt <= 2'h0;
         st_ff.done <= 1'b0;
         st_ff.val <= STRAP_RESET;
      end
      else
         st_ff <= nxt_st;
   end

   assign Q = st_ff.val;
   assign DONE = st_ff.done;

endmodule

// ===== src/hub_strap_capture_status.sv
`timescale 1ns/1ps
// Contract
// - high-speed status output low at low/full speed, high in high-speed mode.
// - superspeed status output high in superspeed mode, low otherwise.
// - power-management strap latched at reset release; low enables full management.
// - with full management, downstream power follows the power-on output.
// - serial mode: latched power-management strap is slave address bit 1.
// - ganged strap latched at release; low individual, high ganged switching.
// - serial mode: latched ganged strap is slave address bit 2.
// - indicator strap latched at release; low enables port indicator leds.
// - serial mode: latched indicator strap is slave address bit 3.
// - reduced-pin package holds slave address bits 2 and 3 at one.
// - mode select high means eeprom master, low means serial slave.
// - slave address is 1000 then bits 3,2,1, then direction bit.
module hub_strap_capture_status import hub_strap_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic POWER_MGMT_STRAP_ADDR1,
   input wire logic GANG_POWER_STRAP_ADDR2,
   input wire logic INDICATOR_STRAP_ADDR3,
   input wire logic REDUCED_PIN_PKG,
   input wire logic SERIAL_MODE_SELECT,
   input wire logic UPSTREAM_HSPD_ACTIVE,
   input wire logic UPSTREAM_SS_ACTIVE,
   output logic HIGH_SPEED_STATUS,
   output logic SUPER_SPEED_STATUS,
   output logic DOWNSTREAM_POWER_ON,
   output logic FULL_PM_EN,
   output logic GANGED_POWER_MODE,
   output logic PORT_INDICATOR_EN,
   output logic EEPROM_MODE,
   output logic STRAPS_VALID,
   output logic [6:0] SMBUS_SLAVE_ADDR,
   input wire logic [AXI_AW-1:0] S_AXI_AWADDR,
   input wire logic [2:0] S_AXI_AWPROT,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [AXI_DW-1:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [AXI_AW-1:0] S_AXI_ARADDR,
   input wire logic [2:0] S_AXI_ARPROT,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [AXI_DW-1:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed
   {
      logic pwr_req;
      logic aw_held;
      logic [AXI_AW-1:0] awaddr;
      logic w_held;
      logic [AXI_DW-1:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [AXI_DW-1:0] rdata;
      logic [1:0] rresp;
      logic hspd;
      logic ss;
      logic dpo;
      logic [6:0] addr;
   } hub_st_t;

   hub_st_t st_ff;
   hub_st_t nxt_st;

   logic [STRAP_W-1:0] pins_sync;
   logic [STRAP_W-1:0] strap_q;
   logic mode_sync;
   logic straps_done;
   logic full_pm;
   logic wr_go;
   logic [AXI_DW-1:0] strap_word;
   logic [AXI_DW-1:0] link_word;

   // ***************************************************************
   // pin capture
   // ***************************************************************
   sync2 #(.W(STRAP_W + 1)) u_pin_sync
   (
      .CLK(CLK_SYS),
      .RST_N(RST_N),
      .D({SERIAL_MODE_SELECT, REDUCED_PIN_PKG, INDICATOR_STRAP_ADDR3,
          GANG_POWER_STRAP_ADDR2, POWER_MGMT_STRAP_ADDR1}),
      .Q({mode_sync, pins_sync})
   );

   strap_latch u_strap_latch
   (
      .CLK(CLK_SYS),
      .RST_N(RST_N),
      .D(pins_sync),
      .Q(strap_q),
      .DONE(straps_done)
   );

   // strap low means full management supported
   assign full_pm = straps_done & ~strap_q[SV_PM];

   // ***************************************************************
   // register read views
   // ***************************************************************
   always_comb
   begin
      strap_word = '0;
      strap_word[ST_PM_BIT] = strap_q[SV_PM];
      strap_word[ST_GANG_BIT] = strap_q[SV_GANG];
      strap_word[ST_IND_BIT] = strap_q[SV_IND];
      strap_word[ST_PKG_BIT] = strap_q[SV_PKG];
      strap_word[ST_EEPROM_BIT] = mode_sync;
      strap_word[ST_DONE_BIT] = straps_done;
      // write-direction form of the address byte
      strap_word[ST_ADDR_LSB +: 8] = {st_ff.addr, SMB_DIR_WRITE};
      link_word = '0;
      link_word[LK_HSPD_BIT] = st_ff.hspd;
      link_word[LK_SS_BIT] = st_ff.ss;
   end

   assign wr_go = st_ff.aw_held & st_ff.w_held & ~st_ff.bvalid;

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb
   begin
      nxt_st = st_ff;

      // address and data accepted in either order, one write in flight
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
         nxt_st.aw_held = 1'b1;
         nxt_st.awaddr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
         nxt_st.w_held = 1'b1;
         nxt_st.wdata = S_AXI_WDATA;
         nxt_st.wstrb = S_AXI_WSTRB;
      end
      if (wr_go)
      begin
         nxt_st.aw_held = 1'b0;
         nxt_st.w_held = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = RESP_OKAY;
         unique case (st_ff.awaddr)
            CTRL_OFS:
            begin
               if (st_ff.wstrb[0])
                  nxt_st.pwr_req = st_ff.wdata[CTRL_PWR_BIT];
            end
            // read-only words ignore writes
            STRAP_OFS, LINK_OFS:
               nxt_st.bresp = RESP_OKAY;
            default:
               nxt_st.bresp = RESP_SLVERR;
         endcase
      end
      if (st_ff.bvalid && S_AXI_BREADY)
         nxt_st.bvalid = 1'b0;

      // reads answer one cycle after the address is taken
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = RESP_OKAY;
         unique case (S_AXI_ARADDR)
            CTRL_OFS:
               nxt_st.rdata = {{(AXI_DW - 1){1'b0}}, st_ff.pwr_req};
            STRAP_OFS:
               nxt_st.rdata = strap_word;
            LINK_OFS:
               nxt_st.rdata = link_word;
            default:
            begin
               nxt_st.rdata = '0;
               nxt_st.rresp = RESP_SLVERR;
            end
         endcase
      end
      else if (st_ff.rvalid && S_AXI_RREADY)
         nxt_st.rvalid = 1'b0;

      // upstream speed indication, same clock as the hub core
      nxt_st.hspd = UPSTREAM_HSPD_ACTIVE;
      nxt_st.ss = UPSTREAM_SS_ACTIVE;

      // ports stay unpowered until the straps are known
      if (!straps_done)
         nxt_st.dpo = 1'b0;
      else if (full_pm)
         nxt_st.dpo = st_ff.pwr_req;
      else
         nxt_st.dpo = 1'b1;

      nxt_st.addr[6:3] = ADDR_FIXED;
      nxt_st.addr[2] = strap_q[SV_PKG] | strap_q[SV_IND];
      nxt_st.addr[1] = strap_q[SV_PKG] | strap_q[SV_GANG];
      nxt_st.addr[0] = strap_q[SV_PM];
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         st_ff <= '0;
         st_ff.pwr_req <= CTRL_PWR_RESET;
      end
      else
         st_ff <= nxt_st;
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign S_AXI_AWREADY = ~st_ff.aw_held;
   assign S_AXI_WREADY = ~st_ff.w_held;
   assign S_AXI_BVALID = st_ff.bvalid;
   assign S_AXI_BRESP = st_ff.bresp;
   assign S_AXI_ARREADY = ~st_ff.rvalid;
   assign S_AXI_RVALID = st_ff.rvalid;
   assign S_AXI_RDATA = st_ff.rdata;
   assign S_AXI_RRESP = st_ff.rresp;
   assign HIGH_SPEED_STATUS = st_ff.hspd;
   assign SUPER_SPEED_STATUS = st_ff.ss;
   assign DOWNSTREAM_POWER_ON = st_ff.dpo;
   assign FULL_PM_EN = full_pm;
   assign GANGED_POWER_MODE = straps_done & strap_q[SV_GANG];
   assign PORT_INDICATOR_EN = straps_done & ~strap_q[SV_IND];
   assign EEPROM_MODE = mode_sync;
   assign STRAPS_VALID = straps_done;
   assign SMBUS_SLAVE_ADDR = st_ff.addr;

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);

   // the release edge still resets the flop, so no attempt starts there
   property p_hspd_follow;
      RST_N && UPSTREAM_HSPD_ACTIVE |=> HIGH_SPEED_STATUS;
   endproperty
   a_hspd_follow: assert property (p_hspd_follow) else $error("hspd status not high");

   property p_hspd_low;
      !UPSTREAM_HSPD_ACTIVE |=> !HIGH_SPEED_STATUS;
   endproperty
   a_hspd_low: assert property (p_hspd_low) else $error("hspd status not low");

   property p_ss_follow;
      RST_N && (UPSTREAM_SS_ACTIVE != $past(UPSTREAM_SS_ACTIVE)) |=>
         SUPER_SPEED_STATUS == $past(UPSTREAM_SS_ACTIVE);
   endproperty
   a_ss_follow: assert property (p_ss_follow) else $error("ss status wrong");

   property p_pm_latch;
      $rose(straps_done) |-> FULL_PM_EN == !$past(pins_sync[SV_PM]);
   endproperty
   a_pm_latch: assert property (p_pm_latch) else $error("pm strap wrong");

   property p_power_ctrl;
      FULL_PM_EN && !st_ff.pwr_req ##1 FULL_PM_EN |-> !DOWNSTREAM_POWER_ON;
   endproperty
   a_power_ctrl: assert property (p_power_ctrl) else $error("power not off");

   property p_addr1;
      straps_done ##1 straps_done |-> SMBUS_SLAVE_ADDR[0] == strap_q[SV_PM];
   endproperty
   a_addr1: assert property (p_addr1) else $error("addr bit 1 wrong");

   property p_gang_latch;
      $rose(straps_done) |-> GANGED_POWER_MODE == $past(pins_sync[SV_GANG]);
   endproperty
   a_gang_latch: assert property (p_gang_latch) else $error("gang strap wrong");

   property p_addr2;
      straps_done ##1 straps_done && !strap_q[SV_PKG] |->
         SMBUS_SLAVE_ADDR[1] == strap_q[SV_GANG];
   endproperty
   a_addr2: assert property (p_addr2) else $error("addr bit 2 wrong");

   property p_ind_latch;
      $rose(straps_done) |-> PORT_INDICATOR_EN == !$past(pins_sync[SV_IND]);
   endproperty
   a_ind_latch: assert property (p_ind_latch) else $error("ind strap wrong");

   property p_addr3;
      straps_done ##1 straps_done && !strap_q[SV_PKG] |->
         SMBUS_SLAVE_ADDR[2] == strap_q[SV_IND];
   endproperty
   a_addr3: assert property (p_addr3) else $error("addr bit 3 wrong");

   property p_reduced;
      straps_done ##1 straps_done && strap_q[SV_PKG] |->
         SMBUS_SLAVE_ADDR[2:1] == 2'h3;
   endproperty
   a_reduced: assert property (p_reduced) else $error("reduced pkg addr");

   property p_mode;
      $past(RST_N) && $past(RST_N, 2) |-> EEPROM_MODE == $past(SERIAL_MODE_SELECT, 2);
   endproperty
   a_mode: assert property (p_mode) else $error("mode select wrong");

   property p_fixed;
      straps_done ##1 straps_done |-> SMBUS_SLAVE_ADDR[6:3] == 4'h8;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed addr wrong");

   property p_hold;
      straps_done |=> straps_done && $stable(strap_q);
   endproperty
   a_hold: assert property (p_hold) else $error("strap changed");

   property p_capture_time;
      $fell(straps_done) or (!straps_done ##1 !straps_done ##1 !straps_done)
         |-> ##[0:3] straps_done;
   endproperty
   a_capture_time: assert property (p_capture_time) else $error("capture late");

   c_capture: cover property ($rose(straps_done));
   c_hspd_up: cover property ($rose(HIGH_SPEED_STATUS));
   c_pwr_off: cover property (FULL_PM_EN ##1 !DOWNSTREAM_POWER_ON);
   c_reduced: cover property (straps_done && strap_q[SV_PKG]);

endmodule

// ===== tb/strap_board.sv
`timescale 1ns/1ps
// ***************************************************************
// board strap resistors and serial host
// ***************************************************************
module strap_board import hub_strap_pkg::*;
(
   input wire logic DRIVE,
   input wire logic [STRAP_W-1:0] CFG,
   output logic PM_PIN,
   output logic GANG_PIN,
   output logic IND_PIN,
   output logic PKG_PIN,
   output logic [7:0] HOST_WR_BYTE
);
   logic [STRAP_W-1:0] lvl;
   // unfitted straps float to the pull-up level
   assign lvl = DRIVE ? CFG : 4'hF;
   assign PM_PIN = lvl[SV_PM];
   assign GANG_PIN = lvl[SV_GANG];
   assign IND_PIN = lvl[SV_IND];
   assign PKG_PIN = lvl[SV_PKG];
   // host side forms the write byte; reduced package pins i and g high
   assign HOST_WR_BYTE = {ADDR_FIXED, lvl[SV_PKG] | lvl[SV_IND],
                          lvl[SV_PKG] | lvl[SV_GANG], lvl[SV_PM], SMB_DIR_WRITE};
endmodule

// ===== tb/hub_strap_capture_status_test.sv
`timescale 1ns/1ps
module hub_strap_capture_status_test import hub_strap_pkg::*;
;
   logic clk_sys, rst_n, pm_pin, gang_pin, ind_pin, pkg_pin, mode_sel, hspd_in, ss_in, drive;
   logic hspd_st, ss_st, dn_pwr, full_pm, ganged, ind_en, eeprom, straps_ok;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [6:0] slv_addr;
   logic [7:0] awaddr, araddr, host_byte;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [3:0] cfg;
   int num_errors, check_count;

   strap_board strap_board_inst (.DRIVE(drive), .CFG(cfg), .PM_PIN(pm_pin),
      .GANG_PIN(gang_pin), .IND_PIN(ind_pin), .PKG_PIN(pkg_pin), .HOST_WR_BYTE(host_byte));

   hub_strap_capture_status hub_strap_capture_status_inst (.CLK_SYS(clk_sys), .RST_N(rst_n),
      .POWER_MGMT_STRAP_ADDR1(pm_pin), .GANG_POWER_STRAP_ADDR2(gang_pin),
      .INDICATOR_STRAP_ADDR3(ind_pin), .REDUCED_PIN_PKG(pkg_pin),
      .SERIAL_MODE_SELECT(mode_sel), .UPSTREAM_HSPD_ACTIVE(hspd_in), .UPSTREAM_SS_ACTIVE(ss_in),
      .HIGH_SPEED_STATUS(hspd_st), .SUPER_SPEED_STATUS(ss_st), .DOWNSTREAM_POWER_ON(dn_pwr),
      .FULL_PM_EN(full_pm), .GANGED_POWER_MODE(ganged), .PORT_INDICATOR_EN(ind_en),
      .EEPROM_MODE(eeprom), .STRAPS_VALID(straps_ok), .SMBUS_SLAVE_ADDR(slv_addr),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // waits without limit; only the watchdog ends a hung transfer
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      forever
      begin
         @(posedge clk_sys);
         if (awvalid && awready)
            awvalid <= 1'h0;
         if (wvalid && wready)
            wvalid <= 1'h0;
         if (bvalid)
         begin
            r = bresp;
            bready <= 1'h0;
            break;
         end
      end
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      forever
      begin
         @(posedge clk_sys);
         if (arvalid && arready)
            arvalid <= 1'h0;
         if (rvalid)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'h0;
            break;
         end
      end
   endtask

   // straps held steady well past the capture edge
   task automatic do_reset(input logic dr, input logic [3:0] c, input int n);
      @(posedge clk_sys);
      drive <= dr;
      cfg <= c;
      rst_n <= 1'h0;
      repeat (n) @(posedge clk_sys);
      chk(straps_ok, 1'h0);
      rst_n <= 1'h1;
      repeat (6) @(posedge clk_sys);
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_straps(input logic dr, input logic [3:0] c);
      logic [31:0] d;
      logic [1:0] r;
      logic [3:0] v;
      logic [7:0] e;
      v = dr ? c : 4'hF;
      do_reset(dr, c, 2);
      chk(straps_ok, 1'h1);
      chk(full_pm, !v[SV_PM]);
      chk(ganged, v[SV_GANG]);
      chk(ind_en, !v[SV_IND]);
      chk({slv_addr, 1'h0}, host_byte);
      axi_rd(STRAP_OFS, d, r);
      chk(d, {16'h0, host_byte, 4'h2, v});
      e = host_byte;
      cfg <= ~c;
      repeat (4) @(posedge clk_sys);
      #1;
      chk(slv_addr, e[7:1]);
      chk({full_pm, ganged, ind_en}, {!v[SV_PM], v[SV_GANG], !v[SV_IND]});
   endtask

   task automatic t_link;
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk_sys);
         hspd_in <= i[0];
         ss_in <= i[1];
         @(posedge clk_sys);
         #1;
         chk({hspd_st, ss_st}, {i[0], i[1]});
      end
      axi_rd(LINK_OFS, d, r);
      chk(d, 32'h3);
   endtask

   task automatic t_mode;
      for (int m = 1; m >= 0; m--)
      begin
         @(posedge clk_sys);
         mode_sel <= m[0];
         repeat (2) @(posedge clk_sys);
         #1;
         chk(eeprom, m[0]);
      end
   endtask

   // without full management the request bit must not switch power
   task automatic t_power;
      logic [31:0] d;
      logic [1:0] r;
      do_reset(1'h1, 4'h0, 2);
      chk(dn_pwr, 1'h1);
      for (int k = 0; k < 2; k++)
      begin
         axi_wr(CTRL_OFS, k, r);
         chk(r, RESP_OKAY);
         repeat (2) @(posedge clk_sys);
         #1;
         chk(dn_pwr, k[0]);
         axi_rd(CTRL_OFS, d, r);
         chk(d, k);
      end
      do_reset(1'h1, 4'h1, 2);
      axi_wr(CTRL_OFS, 32'h0, r);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(dn_pwr, 1'h1);
   endtask

   task automatic t_axi_err;
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(8'h0C, d, r);
      chk(d, 32'h0);
      chk(r, RESP_SLVERR);
      axi_wr(8'h0C, 32'hFFFFFFFF, r);
      chk(r, RESP_SLVERR);
      axi_wr(STRAP_OFS, 32'h0, r);
      chk(r, RESP_OKAY);
   endtask

   // ***************************************************************
   // run
   // ***************************************************************
   initial
   begin
      clk_sys = 1'h0;
      forever #50 clk_sys = ~clk_sys;
   end

   initial
   begin
      repeat (5000) @(posedge clk_sys);
      num_errors++;
      test_done();
   end

   initial
   begin
      {rst_n, mode_sel, hspd_in, ss_in, awvalid, wvalid, bready, arvalid, rready} = 9'h0;
      {drive, cfg, awaddr, araddr, wdata} = 53'h0;
      num_errors = 0;
      check_count = 0;
      do_reset(1'h1, 4'h0, 10);
      t_link();
      t_mode();
      t_power();
      t_axi_err();
      t_straps(1'h1, 4'h0);
      t_straps(1'h1, 4'h6);
      t_straps(1'h1, 4'h9);
      t_straps(1'h1, 4'h5);
      t_straps(1'h0, 4'h0);
      test_done();
   end
endmodule
